// ===== vpsc_pkg.sv
package vpsc_pkg;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] VPSC_CMD_OFS    = 8'h00;
	localparam logic [7:0] VPSC_CTRL_OFS   = 8'h04;
	localparam logic [7:0] VPSC_STATUS_OFS = 8'h08;
	localparam logic [7:0] VPSC_REF_OFS    = 8'h0C;

	// Command register fields
	localparam int unsigned VPSC_CMD_VID_LSB = 0;
	localparam int unsigned VPSC_CMD_OP_LSB  = 8;
	localparam int unsigned VPSC_CMD_PS_LSB  = 12;

	// Control register fields and reset value
	localparam int unsigned VPSC_CTRL_OSR_BIT = 0;
	localparam int unsigned VPSC_CTRL_USR_BIT = 1;
	localparam logic [1:0]  VPSC_CTRL_RST     = 2'h3;

	// Voltage code decode: LSB step and level of code 01, in mV
	localparam int unsigned VPSC_VID_LSB_MV  = 5;
	localparam int unsigned VPSC_VID_BASE_MV = 250;
	localparam logic [7:0]  VPSC_VID_RST     = 8'h00;

	// Slew select pin setting to fast slew rate, mV per us
	localparam int unsigned VPSC_SLEW_MV_US [8] = '{12, 4, 8, 12, 16, 20, 23, 26};
	localparam int unsigned VPSC_CLK_MHZ    = 25;
	localparam int unsigned VPSC_SLOW_DIV   = 4;
	localparam int unsigned VPSC_DECAY_DIV  = 8;

	// Skip select strap codes
	localparam logic [1:0] VPSC_SKIP_OSR_OFF = 2'h1;
	localparam logic [1:0] VPSC_SKIP_USR_OFF = 2'h2;

	typedef enum logic [1:0]
	{
		full_power_state,
		low_power_state_one,
		low_power_state_two,
		low_power_state_three
	} vpsc_pstate_type;

	typedef enum logic [1:0]
	{
		fast_voltage_change_cmd,
		slow_voltage_change_cmd,
		decay_voltage_change_cmd,
		set_power_state_cmd
	} vpsc_op_type;

	// Cycles per code step at a fast slew; least time, so rounded up
	function automatic logic [9:0] vpsc_step_cycles(input logic [2:0] sel);
		int unsigned num;
		num = VPSC_VID_LSB_MV * VPSC_CLK_MHZ;
		return 10'((num + VPSC_SLEW_MV_US[sel] - 1) / VPSC_SLEW_MV_US[sel]);
	endfunction : vpsc_step_cycles

endpackage : vpsc_pkg

// ===== vpsc_phase_trim.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Per-phase on-time trim
// ------------------------------------------------------------------
module vpsc_phase_trim
	import vpsc_pkg::*;
#(
	parameter int unsigned TRIM_W = 5
)
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              active,
	input  wire logic              pulse,
	input  wire logic              above_avg,
	input  wire logic              below_avg,
	output logic signed [TRIM_W-1:0] trim_q
);

	localparam logic signed [TRIM_W-1:0] TRIM_MAX = {1'b0, {(TRIM_W-1){1'b1}}};
	localparam logic signed [TRIM_W-1:0] TRIM_MIN = {1'b1, {(TRIM_W-1){1'b0}}};

	initial
	begin
		if (TRIM_W < 2)
			$error("trim width too small");
	end

	wire shorten = pulse && above_avg && !below_avg && (trim_q != TRIM_MIN);
	wire lengthen = pulse && below_avg && !above_avg && (trim_q != TRIM_MAX);

	// Adjusted on a pulse of this phase that is above or below average, up to the limits; idle phase forgets its history
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			trim_q <= '0;
		else if (!active)
			trim_q <= '0;
		else if (shorten)
			trim_q <= trim_q - 1'b1;
		else if (lengthen)
			trim_q <= trim_q + 1'b1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_trim_direction: assert property (active && pulse && above_avg && !below_avg
		&& trim_q != TRIM_MIN |=> $signed(trim_q) < $signed($past(trim_q)))
		else $error("trim did not shorten above average");

endmodule : vpsc_phase_trim

// ===== vpsc_ctrl.sv
`timescale 1ns/1ps


module vpsc_ctrl
	import vpsc_pkg::*;
#(
	parameter int unsigned MAX_PHASES = 3,
	parameter int unsigned TRIM_W     = 5
)
(
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic [31:0]                   hrdata,
	output logic                          hresp,
	input  wire logic [1:0]               cpu_phase_cfg,
	input  wire logic                     gpu_two_phase,
	input  wire logic [2:0]               slew_select_pin,
	input  wire logic [1:0]               skip_select_pin,
	input  wire logic                     switching_trigger,
	input  wire logic                     overshoot_detect,
	input  wire logic                     undershoot_detect,
	input  wire logic                     load_discharged,
	input  wire logic [MAX_PHASES-1:0]    phase_above_avg,
	input  wire logic [MAX_PHASES-1:0]    phase_below_avg,
	output vpsc_pstate_type               power_state_q,
	output logic [MAX_PHASES-1:0]         cpu_phase_en_q,
	output logic [MAX_PHASES-1:0]         cpu_phase_pulse_q,
	output logic                          forced_continuous_conduction_q,
	output logic                          gpu_diode_emulation_q,
	output logic [10:0]                   reference_dac_level_q,
	output logic                          droop_gain_boost_q,
	output logic                          low_side_off_q,
	output logic                          pulse_overlap_q,
	output logic [MAX_PHASES*TRIM_W-1:0]  phase_trim_q
);

	initial
	begin
		if (MAX_PHASES != 3)
			$error("phase pointer logic serves exactly three phases");
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	logic       wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [1:0] ctrl_q;

	wire        take      = hsel && hready && htrans[1];
	wire        take_wr   = take && hwrite;
	wire        take_rd   = take && !hwrite;
	wire        cmd_wr    = wr_pend_q && (wr_addr_q == VPSC_CMD_OFS);
	wire        ctrl_wr   = wr_pend_q && (wr_addr_q == VPSC_CTRL_OFS);
	wire [7:0]  cmd_vid   = hwdata[VPSC_CMD_VID_LSB +: 8];
	wire [1:0]  cmd_op    = hwdata[VPSC_CMD_OP_LSB +: 2];
	wire [1:0]  cmd_ps    = hwdata[VPSC_CMD_PS_LSB +: 2];

	// Address phase is latched; write data lands one cycle later
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end
		else
		begin
			wr_pend_q <= take_wr;
			wr_addr_q <= haddr[7:0];
		end
	end

	// Zero wait state, always OKAY
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Commands and power state
	// ----------------------------------------------------------------
	logic [7:0] vid_q;
	logic [7:0] target_q;
	logic [1:0] ramp_op_q;

	wire op_fast  = cmd_wr && (cmd_op == 2'(fast_voltage_change_cmd));
	wire op_slow  = cmd_wr && (cmd_op == 2'(slow_voltage_change_cmd));
	wire op_decay = cmd_wr && (cmd_op == 2'(decay_voltage_change_cmd));
	wire op_ps    = cmd_wr && (cmd_op == 2'(set_power_state_cmd));
	wire op_vid   = op_fast || op_slow || op_decay;

	// State changes only on a command; otherwise it holds
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			power_state_q <= full_power_state;
		else if (op_fast || op_slow)
			power_state_q <= full_power_state;
		else if (op_decay)
			power_state_q <= low_power_state_two;
		else if (op_ps)
			power_state_q <= vpsc_pstate_type'(cmd_ps);
	end

	// Control register, software side of the skip features
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ctrl_q <= VPSC_CTRL_RST;
		else if (ctrl_wr)
			ctrl_q <= hwdata[1:0];
	end

	// ----------------------------------------------------------------
	// Reference ramp
	// ----------------------------------------------------------------
	logic [9:0] step_cnt_q;

	wire [9:0] fast_cyc  = vpsc_step_cycles(slew_select_pin);
	wire [9:0] step_cyc  = (ramp_op_q == 2'(slow_voltage_change_cmd))
		? 10'(fast_cyc * VPSC_SLOW_DIV)
		: (ramp_op_q == 2'(decay_voltage_change_cmd))
		? 10'(fast_cyc * VPSC_DECAY_DIV)
		: fast_cyc;
	wire       ramping   = (vid_q != target_q);
	wire       step_due  = ramping && (step_cnt_q >= step_cyc - 10'd1);
	// Decay waits on the load too, so the slower of the two wins
	wire       decay_hold = (ramp_op_q == 2'(decay_voltage_change_cmd))
		&& !load_discharged;
	wire       step_en   = step_due && !decay_hold;

	// Divider for code steps; restarts on each new voltage change command
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			step_cnt_q <= 10'd0;
		else if (op_vid || !ramping || step_en)
			step_cnt_q <= 10'd0;
		else if (!step_due)
			step_cnt_q <= step_cnt_q + 10'd1;
	end

	// Target and walking code
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			vid_q     <= VPSC_VID_RST;
			target_q  <= VPSC_VID_RST;
			ramp_op_q <= 2'(fast_voltage_change_cmd);
		end
		else if (op_vid)
		begin
			target_q  <= cmd_vid;
			ramp_op_q <= cmd_op;
		end
		else if (step_en)
			vid_q <= (target_q > vid_q) ? vid_q + 8'd1 : vid_q - 8'd1;
	end

	// Code to millivolts; code 00 is a hard zero
	wire [10:0] ref_mv = (vid_q == 8'h00) ? 11'd0
		: 11'(VPSC_VID_BASE_MV + VPSC_VID_LSB_MV * (vid_q - 8'd1));

	// Gain boost lasts for a fast upward ramp
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reference_dac_level_q <= 11'd0;
			droop_gain_boost_q    <= 1'b0;
		end
		else
		begin
			reference_dac_level_q <= ref_mv;
			droop_gain_boost_q    <= (ramp_op_q == 2'(fast_voltage_change_cmd))
				&& (target_q > vid_q);
		end
	end

	// ----------------------------------------------------------------
	// Phase count, conduction mode, interleave
	// ----------------------------------------------------------------
	logic [1:0] ptr_q;

	wire       full_pw  = (power_state_q == full_power_state);
	wire [1:0] n_active = (cpu_phase_cfg == 2'd0) ? 2'd0
		: full_pw ? cpu_phase_cfg : 2'd1;
	wire [2:0] en_mask  = (n_active == 2'd3) ? 3'b111
		: (n_active == 2'd2) ? 3'b011
		: (n_active == 2'd1) ? 3'b001 : 3'b000;
	wire [1:0] ptr_next = (ptr_q + 2'd1 >= n_active) ? 2'd0 : ptr_q + 2'd1;
	wire       fire     = switching_trigger && (n_active != 2'd0);

	// Pointer restarts at phase one when the count shrinks under it
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ptr_q <= 2'd0;
		else if (ptr_q >= n_active)
			ptr_q <= 2'd0;
		else if (fire)
			ptr_q <= ptr_next;
	end

	// Registered modes and one-cycle phase pulses
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cpu_phase_en_q                 <= '0;
			cpu_phase_pulse_q              <= '0;
			forced_continuous_conduction_q <= 1'b0;
			gpu_diode_emulation_q          <= 1'b1;
		end
		else
		begin
			cpu_phase_en_q                 <= en_mask;
			cpu_phase_pulse_q              <= fire && (ptr_q < n_active)
				? 3'(3'b001 << ptr_q) : 3'b000;
			forced_continuous_conduction_q <= full_pw;
			gpu_diode_emulation_q          <= !gpu_two_phase || !full_pw;
		end
	end

	// ----------------------------------------------------------------
	// Overshoot and undershoot reduction
	// ----------------------------------------------------------------
	logic       strap_done_q;
	logic [1:0] strap_q;

	// Strap caught once, on the first edge after reset release
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			strap_done_q <= 1'b0;
			strap_q      <= 2'h0;
		end
		else if (!strap_done_q)
		begin
			strap_done_q <= 1'b1;
			strap_q      <= skip_select_pin;
		end
	end

	wire osr_on = strap_done_q && ctrl_q[VPSC_CTRL_OSR_BIT]
		&& (strap_q != VPSC_SKIP_OSR_OFF);
	wire usr_on = strap_done_q && ctrl_q[VPSC_CTRL_USR_BIT]
		&& (strap_q != VPSC_SKIP_USR_OFF);

	// Both follow their comparator, so release is as prompt as entry
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			low_side_off_q  <= 1'b0;
			pulse_overlap_q <= 1'b0;
		end
		else
		begin
			low_side_off_q  <= osr_on && overshoot_detect;
			pulse_overlap_q <= usr_on && undershoot_detect;
		end
	end

	// ----------------------------------------------------------------
	// Current sharing
	// ----------------------------------------------------------------
	for (genvar p = 0; p < MAX_PHASES; p++)
	begin : g_trim
		vpsc_phase_trim #(.TRIM_W(TRIM_W)) u_trim
		(
			.clk       (clk),
			.rst_b     (rst_b),
			.active    (cpu_phase_en_q[p]),
			.pulse     (cpu_phase_pulse_q[p]),
			.above_avg (phase_above_avg[p]),
			.below_avg (phase_below_avg[p]),
			.trim_q    (phase_trim_q[p*TRIM_W +: TRIM_W])
		);
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	wire [31:0] status_word = {16'h0000, 2'h0, strap_q, 1'b0, pulse_overlap_q,
		low_side_off_q, droop_gain_boost_q, forced_continuous_conduction_q,
		gpu_diode_emulation_q, cpu_phase_en_q, ramping, 2'(power_state_q)};
	wire [31:0] ref_word    = {5'h00, reference_dac_level_q, target_q, vid_q};
	wire [31:0] rd_word     = (haddr[7:0] == VPSC_CTRL_OFS)   ? {30'h0, ctrl_q}
		: (haddr[7:0] == VPSC_STATUS_OFS) ? status_word
		: (haddr[7:0] == VPSC_REF_OFS)    ? ref_word
		: 32'h0000_0000;

	// Read data captured in the address phase; unmapped reads zero
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			hrdata <= 32'h0000_0000;
		else if (take_rd)
			hrdata <= rd_word;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_fast_full_power: assert property ((op_fast || op_slow) |=>
		power_state_q == full_power_state)
		else $error("fast or slow command missed full power");
	a_decay_state_two: assert property (op_decay |=>
		power_state_q == low_power_state_two)
		else $error("decay command missed low power state two");
	a_full_all_phases: assert property (rst_b && full_pw && cpu_phase_cfg == 2'd3 |=>
		cpu_phase_en_q == 3'b111)
		else $error("full power not on all phases");
	a_low_single_phase: assert property (!full_pw && cpu_phase_cfg != 2'd0 |=>
		cpu_phase_en_q == 3'b001)
		else $error("low power not single phase");
	a_mode_follows_state: assert property (rst_b |=> forced_continuous_conduction_q
		== ($past(power_state_q) == full_power_state))
		else $error("conduction mode wrong for state");
	a_low_diode_mode: assert property (!full_pw |=> !forced_continuous_conduction_q)
		else $error("low power not in diode emulation");
	a_gpu_diode_mode: assert property (!gpu_two_phase |=> gpu_diode_emulation_q)
		else $error("single phase gpu left diode emulation");
	a_slow_quarter_rate: assert property (ramp_op_q == 2'(slow_voltage_change_cmd)
		&& !op_vid |-> step_cyc == 10'(fast_cyc * 4))
		else $error("slow ramp not quarter rate");
	a_decay_waits_load: assert property (ramping && !load_discharged && !op_vid
		&& ramp_op_q == 2'(decay_voltage_change_cmd) |=> $stable(vid_q))
		else $error("decay stepped before load discharge");
	a_boost_fast_up: assert property (ramp_op_q == 2'(fast_voltage_change_cmd)
		&& target_q > vid_q |=> droop_gain_boost_q)
		else $error("no gain boost on fast upward step");
	a_code_one_level: assert property (vid_q == 8'h01 |=>
		reference_dac_level_q == 11'd250)
		else $error("code one not 250 mV");
	a_osr_low_side: assert property (osr_on && overshoot_detect |=> low_side_off_q
		##1 (low_side_off_q == ($past(osr_on) && $past(overshoot_detect))))
		else $error("low side not switched off on overshoot");
	a_usr_entry_only: assert property (!undershoot_detect |=> !pulse_overlap_q)
		else $error("overlap without undershoot condition");
	a_strap_osr_off: assert property (strap_done_q && strap_q == VPSC_SKIP_OSR_OFF
		|=> !low_side_off_q)
		else $error("overshoot reduction active though strapped off");
	a_round_robin: assert property (fire && ptr_q < n_active |=>
		cpu_phase_pulse_q == 3'(3'b001 << $past(ptr_q)) && ptr_q == $past(ptr_next))
		else $error("trigger not handed to next phase");
	a_state_holds: assert property (!cmd_wr |=> $stable(power_state_q))
		else $error("power state changed without command");

	c_fast_ramp_up: cover property (op_fast ##[1:20] droop_gain_boost_q);
	c_decay_entry:  cover property (op_decay ##1 power_state_q == low_power_state_two);
	c_three_phase:  cover property (fire && n_active == 2'd3 && ptr_q == 2'd2);
	c_overlap:      cover property (pulse_overlap_q ##1 !pulse_overlap_q);

endmodule : vpsc_ctrl

// ===== vpsc_host.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host side: issues register transfers on the command bus
// ----------------------------------------------------------------
module vpsc_host
(
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	logic [31:0] rd_data;
	event        rd_ev;

	// Idle bus from time zero
	initial
	begin
		hsel   = 1'b0;
		haddr  = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0000_0000;
	end

	// One single word; read data taken at the data phase edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		// Released data lines no longer show the old word
		hwdata <= ~d;
		if (!wr)
		begin
			rd_data = hrdata;
			-> rd_ev;
		end
	endtask : xfer
endmodule : vpsc_host

// ===== vid_power_state_phase_control_bench.sv
`timescale 1ns/1ps

module vid_power_state_phase_control_bench import vpsc_pkg::*;;
	logic            clk = 1'b0;
	logic            rst_b = 1'b0;
	logic            hsel, hwrite, hreadyout, hresp, forced_continuous_conduction, gde, boost, lso, ovl;
	logic [31:0]     haddr, hwdata, hrdata;
	logic [1:0]      htrans, cfg = 2'h3, skip = 2'h0;
	logic [2:0]      hsize, pen, ppl, slew = 3'h0, ab = 3'h0, bl = 3'h0;
	logic            trig = 1'b0, od = 1'b0, ud = 1'b0, ld = 1'b0, gtp = 1'b0;
	vpsc_pstate_type ps;
	logic [10:0]     ref_mv;
	logic [14:0]     trim;
	int              fails = 0, check_count = 0;
	logic [31:0]     exp_q[$], msk_q[$];

	// 25 MHz clock
	always #20 clk = ~clk;

	vpsc_ctrl dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cpu_phase_cfg(cfg),
		.gpu_two_phase(gtp), .slew_select_pin(slew), .skip_select_pin(skip),
		.switching_trigger(trig), .overshoot_detect(od), .undershoot_detect(ud),
		.load_discharged(ld), .phase_above_avg(ab), .phase_below_avg(bl),
		.power_state_q(ps), .cpu_phase_en_q(pen), .cpu_phase_pulse_q(ppl),
		.forced_continuous_conduction_q(forced_continuous_conduction), .gpu_diode_emulation_q(gde),
		.reference_dac_level_q(ref_mv), .droop_gain_boost_q(boost), .low_side_off_q(lso),
		.pulse_overlap_q(ovl), .phase_trim_q(trim));

	vpsc_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// ----------------------------------------------------------------
	// Checking helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	// Read watcher: each read word meets the oldest note
	always @(host.rd_ev)
	begin
		logic [31:0] m;
		m = msk_q.pop_front();
		chk(host.rd_data & m, exp_q.pop_front() & m);
	end

	// Hang guard, well beyond the longest ramp sequence
	initial
	begin
		#800000;
		fails++;
		conclude();
	end

	// Reference in mV for a code
	function automatic logic [10:0] mv(input logic [7:0] v);
		return (v == 8'h00) ? 11'h000 : 11'(250 + 5 * (int'(v) - 1));
	endfunction : mv

	// Status word expected in a state, mask 0xfb skips ramping
	function automatic logic [31:0] st(input logic [1:0] s);
		logic [2:0] en;
		en = (s == 2'h0) ? 3'((4'h1 << cfg) - 4'h1) : 3'h1;
		return {24'h00_0000, s == 2'h0, 1'b1, en, 1'b0, s};
	endfunction : st

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		msk_q.push_back(m);
		exp_q.push_back(e);
		host.xfer(1'b0, a, 32'h5a5a_5a5a);
	endtask : rd

	task automatic cmd(input logic [1:0] op, input logic [1:0] s, input logic [7:0] v);
		host.xfer(1'b1, VPSC_CMD_OFS, {18'h0, s, 2'h0, op, v});
		repeat (3) @(posedge clk);
	endtask : cmd

	// Waits for the reference to reach a code; n counts cycles from the write
	task automatic ramp(input logic [1:0] op, input logic [7:0] v, output int n);
		cmd(op, 2'h0, v);
		n = 3;
		while (ref_mv !== mv(v) && n < 5000)
		begin
			@(posedge clk);
			n++;
		end
	endtask : ramp

	task automatic osr_usr(input logic eo, input logic eu);
		@(posedge clk);
		od <= 1'b1;
		ud <= 1'b1;
		repeat (3) @(negedge clk);
		chk(32'(lso), 32'(eo));
		chk(32'(ovl), 32'(eu));
		@(posedge clk);
		od <= 1'b0;
		ud <= 1'b0;
		repeat (3) @(negedge clk);
		chk(32'({lso, ovl}), 32'h0000_0000);
	endtask : osr_usr

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		int n, nf;
		logic [7:0] v, seen;
		logic [1:0] ops[5] = '{2'h2, 2'h0, 2'h3, 2'h1, 2'h3};
		logic [1:0] pss[5] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h3};
		logic [1:0] exs[5] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h3};
		void'($urandom(32'h0ecd));
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		rd(VPSC_STATUS_OFS, 32'h0000_00fb, st(2'h0));
		rd(VPSC_CTRL_OFS, 32'hffff_ffff, 32'h0000_0003);
		rd(VPSC_REF_OFS, 32'hffff_ffff, 32'h0000_0000);
		rd(8'h40, 32'hffff_ffff, 32'h0000_0000);
		// Every command kind and the state it leaves
		for (int i = 0; i < 5; i++)
		begin
			cmd(ops[i], pss[i], 8'h00);
			rd(VPSC_STATUS_OFS, 32'h0000_00fb, st(exs[i]));
		end
		repeat (200) @(posedge clk);
		rd(VPSC_STATUS_OFS, 32'h0000_0003, 32'h0000_0003);
		cfg <= 2'h2;
		cmd(2'h0, 2'h0, 8'h00);
		rd(VPSC_STATUS_OFS, 32'h0000_00fb, st(2'h0));
		// Two-phase GPU may leave diode emulation in full power only
		gtp <= 1'b1;
		repeat (3) @(posedge clk);
		rd(VPSC_STATUS_OFS, 32'h0000_0040, 32'h0000_0000);
		gtp <= 1'b0;
		chk(32'(hresp), 32'h0000_0000);
		// Random rising ramp: boost while rising, decode at the end
		slew <= 3'($urandom_range(7));
		v = 8'($urandom_range(33, 4));
		cmd(2'h0, 2'h0, v);
		rd(VPSC_STATUS_OFS, 32'h0000_0100, 32'h0000_0100);
		n = 0;
		while (ref_mv !== mv(v) && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		rd(VPSC_REF_OFS, 32'h07ff_ffff, {5'h00, mv(v), v, v});
		// Equal step counts: slow must take far longer than fast
		ramp(2'h0, 8'(v + 4), nf);
		ramp(2'h1, 8'(v + 8), n);
		chk(32'(n > 3 * nf), 32'h0000_0001);
		// Decay stalls while the load holds the output up
		cmd(2'h2, 2'h0, v);
		repeat (100) @(negedge clk);
		chk(32'(ref_mv), 32'(mv(8'(v + 8))));
		@(posedge clk);
		ld <= 1'b1;
		ramp(2'h2, v, n);
		chk(32'(ref_mv), 32'(mv(v)));
		// Round-robin triggers in full power, trims of phases one and three nudged on their pulses
		cfg <= 2'h3;
		ab <= 3'h1;
		bl <= 3'h4;
		cmd(2'h0, 2'h0, v);
		for (int k = 0; k < 6; k++)
		begin
			@(posedge clk);
			trig <= 1'b1;
			@(posedge clk);
			trig <= 1'b0;
			seen = 8'h00;
			repeat (2) @(negedge clk) seen |= 8'(ppl);
			chk(32'(seen), 32'h0000_0001 << (k % 3));
		end
		chk(32'(trim), {17'h0, 5'h02, 5'h00, 5'h1e});
		// Overshoot and undershoot actions by control bits, then by strap
		osr_usr(1'b1, 1'b1);
		host.xfer(1'b1, VPSC_CTRL_OFS, 32'h0000_0000);
		osr_usr(1'b0, 1'b0);
		host.xfer(1'b1, VPSC_CTRL_OFS, 32'h0000_0001);
		osr_usr(1'b1, 1'b0);
		rst_b <= 1'b0;
		skip <= VPSC_SKIP_OSR_OFF;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		osr_usr(1'b0, 1'b1);
		conclude();
	end
endmodule : vid_power_state_phase_control_bench
